// *** design/rpa_pkg.sv ***
/*
 * Package for the pointer-window register block of the calendar clock unit:
 * register offsets, field positions, reset values, key values and bus types.
 * Assumes an AHB-Lite slave with 32-bit data, one aligned word per register.
 */
`default_nettype none
package rpa_pkg;
    // Byte offsets, one word each
    localparam logic [5:0] OFS_CLOCK_CONFIG = 6'h00;
    localparam logic [5:0] OFS_TIME_WINDOW  = 6'h04;
    localparam logic [5:0] OFS_ALARM_CONFIG = 6'h08;
    localparam logic [5:0] OFS_ALARM_WINDOW = 6'h0C;
    localparam logic [5:0] OFS_POWER_CTL    = 6'h10;
    localparam logic [5:0] OFS_UNLOCK_KEY   = 6'h14;

    // Field positions
    localparam int POS_PTR_LO   = 8;
    localparam int POS_PTR_HI   = 9;
    localparam int POS_WREN     = 13;
    localparam int POS_CLKSEL_LO = 10;
    localparam int POS_CLKSEL_HI = 11;

    // Reset values
    localparam logic [1:0]  RST_PTR    = 2'h0;
    localparam logic [1:0]  RST_CLKSEL = 2'h0;
    localparam logic [15:0] RST_VALUE  = 16'h0000;

    // Pointer codes
    localparam logic [1:0] PTR_MIN_SEC  = 2'h0;
    localparam logic [1:0] PTR_YEAR     = 2'h3;

    // Unlock key bytes
    localparam logic [7:0] KEY_FIRST  = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;

    // Transfer size codes
    localparam logic [2:0] SIZE_BYTE = 3'h0;

    typedef enum logic [1:0] {
        RPA_KEY_IDLE = 2'b00,
        RPA_KEY_HALF = 2'b01,
        RPA_KEY_OPEN = 2'b10
    } rpa_key_e;

    typedef struct packed {
        logic [5:0] addr;
        logic       write;
        logic [2:0] size;
    } rpa_aphase_s;
endpackage
`default_nettype wire

// *** design/rpa_unlock_seq.sv ***
/*
 * Two-step key sequencer: a write of the first key byte then the second
 * opens a window that lasts for exactly the next completed bus transfer.
 * Assumes key writes and transfer completions arrive as one-cycle pulses.
 */
`timescale 1ns/10ps
`default_nettype none
module rpa_unlock_seq (
    // Clock and reset
    input  wire logic       hclk,
    input  wire logic       hresetn,
    // Bus events
    input  wire logic       key_wr,
    input  wire logic [7:0] key_data,
    input  wire logic       xfer_done,
    // Result
    output logic            key_open
);
    rpa_pkg::rpa_key_e state_ff;
    rpa_pkg::rpa_key_e nxt_state;

    wire logic is_first  = (key_data == rpa_pkg::KEY_FIRST);
    wire logic is_second = (key_data == rpa_pkg::KEY_SECOND);

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            rpa_pkg::RPA_KEY_IDLE: begin
                if (key_wr && is_first)
                    nxt_state = rpa_pkg::RPA_KEY_HALF;
            end
            rpa_pkg::RPA_KEY_HALF: begin
                // Any other transfer breaks the sequence
                if (key_wr && is_second)
                    nxt_state = rpa_pkg::RPA_KEY_OPEN;
                else if (xfer_done)
                    nxt_state = rpa_pkg::RPA_KEY_IDLE;
            end
            rpa_pkg::RPA_KEY_OPEN: begin
                // One transfer only; then closed again
                if (key_wr && is_first)
                    nxt_state = rpa_pkg::RPA_KEY_HALF;
                else if (xfer_done)
                    nxt_state = rpa_pkg::RPA_KEY_IDLE;
            end
            default: nxt_state = rpa_pkg::RPA_KEY_IDLE;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            state_ff <= rpa_pkg::RPA_KEY_IDLE;
        else
            state_ff <= nxt_state;
    end

    assign key_open = (state_ff == rpa_pkg::RPA_KEY_OPEN);
endmodule
`default_nettype wire

// *** design/rpa_regs.sv ***
/*
 * Register interface of the calendar clock unit: time and alarm windows
 * reached through 2-bit pair pointers, key-guarded time write enable and
 * reference clock select, all behind an AHB-Lite slave.
 * Assumes one AHB-Lite master; hsel qualifies this slave's address range.
 */
// Overview of operation
// - Time pointer in the config register picks which time pair the time window shows.
// - A high-byte write to the time window, while the time write enable is set, steps the time pointer down, holding at 00.
// - Alarm pointer in the alarm config register picks which alarm pair the alarm window shows.
// - A high-byte write to the alarm window steps the alarm pointer down, holding at 00.
// - Any read of the alarm window steps the alarm pointer down.
// - Any read of the time window steps the time pointer down.
// - Low-byte-only writes to a window leave its pointer alone.
// - Time value writes take effect only while the time write enable is set.
// - The time write enable can be set only right after writing 55h then AAh to the key register.
// - A 2-bit field in the power control register selects the reference clock source.
`timescale 1ns/10ps
`default_nettype none
module rpa_regs #(
    parameter int PAIRS = 4
) (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Block state
    output logic [1:0]       time_pair_pointer,
    output logic [1:0]       alarm_pair_pointer,
    output logic             time_write_enable,
    output logic [1:0]       ref_clock_select
);
    // Bus pipeline
    rpa_pkg::rpa_aphase_s dp_ff;
    logic                 wr_pend_ff;
    logic                 rd_pend_ff;
    logic                 hreadyout_ff;
    logic                 hresp_ff;
    logic [31:0]          hrdata_ff;

    // Register state
    logic [1:0]           tptr_ff;
    logic [1:0]           aptr_ff;
    logic                 wren_ff;
    logic [1:0]           clksel_ff;
    logic [15:0]          time_mem_ff  [PAIRS];
    logic [15:0]          alarm_mem_ff [PAIRS];

    logic [1:0]           nxt_tptr;
    logic [1:0]           nxt_aptr;
    logic                 nxt_wren;
    logic [31:0]          nxt_rdata;
    wire logic            key_open;

    function automatic logic [1:0] ptr_step(input logic [1:0] p);
        ptr_step = (p == rpa_pkg::PTR_MIN_SEC) ? rpa_pkg::PTR_MIN_SEC : p - 2'h1;
    endfunction

    // Byte lanes: byte at offset 1 is the high byte, wider sizes hit both
    function automatic logic lane_hi(input rpa_pkg::rpa_aphase_s a);
        lane_hi = (a.size != rpa_pkg::SIZE_BYTE) || a.addr[0];
    endfunction

    function automatic logic lane_lo(input rpa_pkg::rpa_aphase_s a);
        lane_lo = (a.size != rpa_pkg::SIZE_BYTE) || !a.addr[0];
    endfunction

    // Address phase
    wire logic                 take = hsel && htrans[1] && hready;
    wire rpa_pkg::rpa_aphase_s ap   = '{addr: haddr[5:0], write: hwrite, size: hsize};
    wire logic                 hit  = (haddr[31:6] == 26'h0000000);

    // Data phase decode
    wire logic [5:0] dword = {dp_ff.addr[5:2], 2'b00};
    wire logic sel_cfg   = (dword == rpa_pkg::OFS_CLOCK_CONFIG);
    wire logic sel_time  = (dword == rpa_pkg::OFS_TIME_WINDOW);
    wire logic sel_acfg  = (dword == rpa_pkg::OFS_ALARM_CONFIG);
    wire logic sel_alarm = (dword == rpa_pkg::OFS_ALARM_WINDOW);
    wire logic sel_pwr   = (dword == rpa_pkg::OFS_POWER_CTL);
    wire logic sel_key   = (dword == rpa_pkg::OFS_UNLOCK_KEY);
    wire logic wr_hi     = wr_pend_ff && lane_hi(dp_ff);
    wire logic wr_lo     = wr_pend_ff && lane_lo(dp_ff);

    wire logic cfg_wr    = wr_hi && sel_cfg;
    wire logic acfg_wr   = wr_hi && sel_acfg;
    wire logic pwr_wr    = wr_hi && sel_pwr;
    wire logic key_wr    = wr_lo && sel_key;
    wire logic time_ok   = wren_ff;
    wire logic time_wr_h = wr_hi && sel_time && time_ok;
    wire logic time_wr_l = wr_lo && sel_time && time_ok;
    wire logic alrm_wr_h = wr_hi && sel_alarm;
    wire logic alrm_wr_l = wr_lo && sel_alarm;
    wire logic time_rd   = rd_pend_ff && sel_time;
    wire logic alrm_rd   = rd_pend_ff && sel_alarm;

    wire logic tptr_step = time_wr_h || time_rd;
    wire logic aptr_step = alrm_wr_h || alrm_rd;

    rpa_unlock_seq u_unlock (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .key_wr    (key_wr),
        .key_data  (hwdata[7:0]),
        .xfer_done (wr_pend_ff || rd_pend_ff),
        .key_open  (key_open)
    );

    // Software write wins over a step in the same cycle
    assign nxt_tptr = cfg_wr ? hwdata[rpa_pkg::POS_PTR_HI:rpa_pkg::POS_PTR_LO]
                    : tptr_step ? ptr_step(tptr_ff) : tptr_ff;
    assign nxt_aptr = acfg_wr ? hwdata[rpa_pkg::POS_PTR_HI:rpa_pkg::POS_PTR_LO]
                    : aptr_step ? ptr_step(aptr_ff) : aptr_ff;
    // Can be held or cleared freely; a fresh set needs the open key window
    assign nxt_wren = cfg_wr ? (hwdata[rpa_pkg::POS_WREN] && (wren_ff || key_open)) : wren_ff;

    // Year pair has no high byte
    wire logic [15:0] time_view  = (tptr_ff == rpa_pkg::PTR_YEAR) ?
                                   {8'h00, time_mem_ff[tptr_ff][7:0]} : time_mem_ff[tptr_ff];
    wire logic [15:0] alarm_view = alarm_mem_ff[aptr_ff];

    always_comb begin
        nxt_rdata = 32'h00000000;
        if (sel_cfg)
            nxt_rdata = {18'h00000, wren_ff, 3'h0, tptr_ff, 8'h00};
        else if (sel_time)
            nxt_rdata = {16'h0000, time_view};
        else if (sel_acfg)
            nxt_rdata = {22'h000000, aptr_ff, 8'h00};
        else if (sel_alarm)
            nxt_rdata = {16'h0000, alarm_view};
        else if (sel_pwr)
            nxt_rdata = {20'h00000, clksel_ff, 10'h000};
    end

    // Bus handshake: writes take no wait, reads take one
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_ff        <= '0;
            wr_pend_ff   <= 1'b0;
            rd_pend_ff   <= 1'b0;
            hreadyout_ff <= 1'b1;
            hresp_ff     <= 1'b0;
            hrdata_ff    <= 32'h00000000;
        end else begin
            wr_pend_ff   <= take && hwrite && hit;
            rd_pend_ff   <= take && !hwrite;
            hreadyout_ff <= !(take && !hwrite);
            if (take)
                dp_ff <= hit ? ap : rpa_pkg::rpa_aphase_s'{addr: 6'h3C, write: hwrite, size: hsize};
            if (rd_pend_ff)
                hrdata_ff <= nxt_rdata;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tptr_ff   <= rpa_pkg::RST_PTR;
            aptr_ff   <= rpa_pkg::RST_PTR;
            wren_ff   <= 1'b0;
            clksel_ff <= rpa_pkg::RST_CLKSEL;
        end else begin
            tptr_ff <= nxt_tptr;
            aptr_ff <= nxt_aptr;
            wren_ff <= nxt_wren;
            if (pwr_wr)
                clksel_ff <= hwdata[rpa_pkg::POS_CLKSEL_HI:rpa_pkg::POS_CLKSEL_LO];
        end
    end

    // Value storage, lanes written separately; slot picked by the current pointer
    for (genvar g = 0; g < PAIRS; g++) begin : g_pair
        wire logic t_here = (tptr_ff == 2'(g));
        wire logic a_here = (aptr_ff == 2'(g));
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                time_mem_ff[g]  <= rpa_pkg::RST_VALUE;
                alarm_mem_ff[g] <= rpa_pkg::RST_VALUE;
            end else begin
                if (t_here && time_wr_h)
                    time_mem_ff[g][15:8] <= hwdata[15:8];
                if (t_here && time_wr_l)
                    time_mem_ff[g][7:0] <= hwdata[7:0];
                if (a_here && alrm_wr_h)
                    alarm_mem_ff[g][15:8] <= hwdata[15:8];
                if (a_here && alrm_wr_l)
                    alarm_mem_ff[g][7:0] <= hwdata[7:0];
            end
        end
    end

    assign hrdata             = hrdata_ff;
    assign hreadyout          = hreadyout_ff;
    assign hresp              = hresp_ff;
    assign time_pair_pointer  = tptr_ff;
    assign alarm_pair_pointer = aptr_ff;
    assign time_write_enable  = wren_ff;
    assign ref_clock_select   = clksel_ff;

    // Checks
    property p_time_hi_wr_step;
        @(posedge hclk) disable iff (!hresetn)
        (time_wr_h && !cfg_wr) |=> (tptr_ff == ptr_step($past(tptr_ff)));
    endproperty
    a_time_hi_wr_step: assert property (p_time_hi_wr_step) else $error("time pointer missed write step");

    property p_alarm_hi_wr_step;
        @(posedge hclk) disable iff (!hresetn)
        (alrm_wr_h && !acfg_wr) |=> (aptr_ff == ptr_step($past(aptr_ff)));
    endproperty
    a_alarm_hi_wr_step: assert property (p_alarm_hi_wr_step) else $error("alarm pointer missed write step");

    property p_alarm_rd_step;
        @(posedge hclk) disable iff (!hresetn)
        (take && !hwrite && hit && haddr[5:2] == rpa_pkg::OFS_ALARM_WINDOW[5:2] && aptr_ff == 2'h2)
        |=> ##1 (aptr_ff == 2'h1);
    endproperty
    a_alarm_rd_step: assert property (p_alarm_rd_step) else $error("alarm read did not step pointer");

    property p_time_rd_step;
        @(posedge hclk) disable iff (!hresetn)
        time_rd |=> (tptr_ff == ptr_step($past(tptr_ff)));
    endproperty
    a_time_rd_step: assert property (p_time_rd_step) else $error("time read did not step pointer");

    property p_lo_wr_hold;
        @(posedge hclk) disable iff (!hresetn)
        (wr_lo && !wr_hi && (sel_time || sel_alarm)) |=> $stable(tptr_ff) && $stable(aptr_ff);
    endproperty
    a_lo_wr_hold: assert property (p_lo_wr_hold) else $error("low byte write moved a pointer");

    property p_locked_time;
        @(posedge hclk) disable iff (!hresetn)
        (wr_pend_ff && sel_time && !wren_ff) |=> (time_mem_ff[$past(tptr_ff)] == $past(time_mem_ff[tptr_ff]))
                                             && (tptr_ff == $past(tptr_ff));
    endproperty
    a_locked_time: assert property (p_locked_time) else $error("locked time write took effect");

    property p_wren_set_needs_key;
        @(posedge hclk) disable iff (!hresetn)
        $rose(wren_ff) |-> $past(key_open) && $past(cfg_wr);
    endproperty
    a_wren_set_needs_key: assert property (p_wren_set_needs_key) else $error("write enable set without key");

    property p_clksel_wr;
        @(posedge hclk) disable iff (!hresetn)
        pwr_wr |=> (ref_clock_select == $past(hwdata[11:10]));
    endproperty
    a_clksel_wr: assert property (p_clksel_wr) else $error("clock select not written");

    property p_ptr_sw_wins;
        @(posedge hclk) disable iff (!hresetn)
        cfg_wr |=> (time_pair_pointer == $past(hwdata[9:8]));
    endproperty
    a_ptr_sw_wins: assert property (p_ptr_sw_wins) else $error("pointer write lost");

    property p_read_one_wait;
        @(posedge hclk) disable iff (!hresetn)
        (take && !hwrite) |=> !hreadyout ##1 hreadyout;
    endproperty
    a_read_one_wait: assert property (p_read_one_wait) else $error("read wait state wrong");

    // Window contents, key window and holds
    property p_time_view_pair;
        @(posedge hclk) disable iff (!hresetn)
        (time_rd && tptr_ff != rpa_pkg::PTR_YEAR) |=> (hrdata == {16'h0000, $past(time_mem_ff[tptr_ff])});
    endproperty
    a_time_view_pair: assert property (p_time_view_pair) else $error("time window showed wrong pair");

    property p_time_view_year;
        @(posedge hclk) disable iff (!hresetn)
        (time_rd && tptr_ff == rpa_pkg::PTR_YEAR) |=> (hrdata == {24'h000000, $past(time_mem_ff[tptr_ff][7:0])});
    endproperty
    a_time_view_year: assert property (p_time_view_year) else $error("year pair high byte not zero");

    property p_alarm_view_pair;
        @(posedge hclk) disable iff (!hresetn)
        alrm_rd |=> (hrdata == {16'h0000, $past(alarm_mem_ff[aptr_ff])});
    endproperty
    a_alarm_view_pair: assert property (p_alarm_view_pair) else $error("alarm window showed wrong pair");

    property p_time_lo_lands;
        @(posedge hclk) disable iff (!hresetn)
        time_wr_l |=> (time_mem_ff[$past(tptr_ff)][7:0] == $past(hwdata[7:0]));
    endproperty
    a_time_lo_lands: assert property (p_time_lo_lands) else $error("enabled time write lost");

    property p_alarm_lo_lands;
        @(posedge hclk) disable iff (!hresetn)
        alrm_wr_l |=> (alarm_mem_ff[$past(aptr_ff)][7:0] == $past(hwdata[7:0]));
    endproperty
    a_alarm_lo_lands: assert property (p_alarm_lo_lands) else $error("alarm write lost");

    property p_wren_closed;
        @(posedge hclk) disable iff (!hresetn)
        (cfg_wr && !key_open && !wren_ff) |=> !wren_ff;
    endproperty
    a_wren_closed: assert property (p_wren_closed) else $error("write enable set with key closed");

    property p_wren_clear;
        @(posedge hclk) disable iff (!hresetn)
        (cfg_wr && !hwdata[rpa_pkg::POS_WREN]) |=> !time_write_enable;
    endproperty
    a_wren_clear: assert property (p_wren_clear) else $error("write enable clear refused");

    property p_key_open_one;
        @(posedge hclk) disable iff (!hresetn)
        (key_open && (wr_pend_ff || rd_pend_ff)) |=> !key_open;
    endproperty
    a_key_open_one: assert property (p_key_open_one) else $error("key window outlived one transfer");

    property p_key_needs_pair;
        @(posedge hclk) disable iff (!hresetn)
        $rose(key_open) |-> $past(key_wr) && ($past(hwdata[7:0]) == rpa_pkg::KEY_SECOND);
    endproperty
    a_key_needs_pair: assert property (p_key_needs_pair) else $error("key window opened without second key");

    property p_clksel_hold;
        @(posedge hclk) disable iff (!hresetn)
        !pwr_wr |=> $stable(clksel_ff);
    endproperty
    a_clksel_hold: assert property (p_clksel_hold) else $error("clock select moved without write");

    property p_tptr_hold;
        @(posedge hclk) disable iff (!hresetn)
        !(cfg_wr || tptr_step) |=> $stable(tptr_ff);
    endproperty
    a_tptr_hold: assert property (p_tptr_hold) else $error("time pointer moved on its own");

    property p_aptr_hold;
        @(posedge hclk) disable iff (!hresetn)
        !(acfg_wr || aptr_step) |=> $stable(aptr_ff);
    endproperty
    a_aptr_hold: assert property (p_aptr_hold) else $error("alarm pointer moved on its own");
endmodule
`default_nettype wire

// *** testbench/testbench.sv ***
/*
 * Self-checking bench for the pointer-window register block.
 * Assumes rpa_pkg and rpa_regs are compiled first; this bench is the AHB-Lite master.
 */
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    wire logic   hready;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic [1:0]  time_pair_pointer;
    logic [1:0]  alarm_pair_pointer;
    logic        time_write_enable;
    logic [1:0]  ref_clock_select;
    int          num_errors;
    int          n_compared;
    logic [31:0] seed;
    logic [15:0] mem [2][4];
    logic [31:0] rd;

    // Single slave: its ready is the bus ready
    assign hready = hreadyout;

    rpa_regs #(.PAIRS(4)) dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .time_pair_pointer(time_pair_pointer),
        .alarm_pair_pointer(alarm_pair_pointer), .time_write_enable(time_write_enable),
        .ref_clock_select(ref_clock_select));

    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end

    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction

    // Time config keeps the enable bit set so pointer moves do not lock writes
    function automatic logic [31:0] cfg_word(input int w, input int p);
        return (w == 0 ? 32'h0000_2000 : 32'h0000_0000) | (32'(p) << rpa_pkg::POS_PTR_LO);
    endfunction

    // Year pair of the time window has no high byte
    function automatic logic [31:0] exp_read(input int w, input int p);
        if (w == 0 && p == 3) return {24'h000000, mem[0][3][7:0]};
        return {16'h0000, mem[w][p]};
    endfunction

    task automatic wrap_up();
        $display("compared %0d, errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic check_data(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED data t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic check_port(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED port t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic xfer(input logic [5:0] a, input logic wr, input logic [2:0] s, input logic [31:0] d,
                        output logic [31:0] r);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {26'h0000000, a};
        htrans <= 2'h2;
        hwrite <= wr;
        hsize  <= s;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        r = hrdata;
        check_data({31'h0, hresp}, 32'h0);
        // Past the commit edge, so pin checks see the new state
        @(negedge hclk);
    endtask

    task automatic wr(input logic [5:0] a, input logic [2:0] s, input logic [31:0] d);
        logic [31:0] dummy;
        xfer(a, 1'b1, s, d, dummy);
    endtask

    task automatic rdw(input logic [5:0] a, output logic [31:0] r);
        xfer(a, 1'b0, 3'h2, 32'h0, r);
    endtask

    task automatic run_window(input int w, input logic [5:0] cfg, input logic [5:0] win);
        logic [31:0] v;
        logic [31:0] r;
        int          p;
        wr(cfg, 3'h2, cfg_word(w, 3));
        // Five writes from pair 3: the last shows the pointer held at 00
        for (p = 3; p >= -1; p--) begin
            v = rnd();
            mem[w][p < 0 ? 0 : p] = v[15:0];
            wr(win, 3'h2, v);
            check_port(w ? alarm_pair_pointer : time_pair_pointer, p > 0 ? p - 1 : 0);
        end
        wr(cfg, 3'h2, cfg_word(w, 2));
        v = rnd();
        mem[w][2][7:0] = v[7:0];
        wr(win, rpa_pkg::SIZE_BYTE, {24'h0, v[7:0]});
        check_port(w ? alarm_pair_pointer : time_pair_pointer, 2);
        mem[w][2][15:8] = v[15:8];
        wr(win + 6'h01, rpa_pkg::SIZE_BYTE, {16'h0, v[15:8], 8'h00});
        check_port(w ? alarm_pair_pointer : time_pair_pointer, 1);
        wr(cfg, 3'h2, cfg_word(w, 3));
        for (p = 3; p >= 0; p--) begin
            rdw(win, r);
            check_data(r, exp_read(w, p));
            check_port(w ? alarm_pair_pointer : time_pair_pointer, p > 0 ? p - 1 : 0);
        end
        wr(cfg, 3'h2, cfg_word(w, 1));
        xfer(win + 6'h01, 1'b0, rpa_pkg::SIZE_BYTE, 32'h0, r);
        check_port(w ? alarm_pair_pointer : time_pair_pointer, 0);
        rdw(cfg, r);
        check_data(r, cfg_word(w, 0));
    endtask

    initial begin
        #(50 * 20000);
        num_errors++;
        wrap_up();
    end

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h0;
        hwdata = 32'h0;
        num_errors = 0;
        n_compared = 0;
        seed = 32'hb3ff;
        foreach (mem[i, j]) mem[i][j] = 16'h0000;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        check_port({27'h0, time_pair_pointer, alarm_pair_pointer, time_write_enable}, 32'h0);
        check_port(ref_clock_select, 32'h0);
        for (int c = 0; c < 4; c++) begin
            wr(rpa_pkg::OFS_POWER_CTL, 3'h2, 32'(c) << rpa_pkg::POS_CLKSEL_LO);
            check_port(ref_clock_select, c);
            rdw(rpa_pkg::OFS_POWER_CTL, rd);
            check_data(rd, 32'(c) << rpa_pkg::POS_CLKSEL_LO);
        end
        // Locked: enable refused without key, time write ignored
        wr(rpa_pkg::OFS_CLOCK_CONFIG, 3'h2, 32'h0000_2000);
        check_port(time_write_enable, 0);
        wr(rpa_pkg::OFS_TIME_WINDOW, 3'h2, rnd());
        rdw(rpa_pkg::OFS_TIME_WINDOW, rd);
        check_data(rd, 32'h0);
        // A transfer between the key bytes cancels the sequence
        wr(rpa_pkg::OFS_UNLOCK_KEY, 3'h2, {24'h0, rpa_pkg::KEY_FIRST});
        rdw(rpa_pkg::OFS_CLOCK_CONFIG, rd);
        wr(rpa_pkg::OFS_UNLOCK_KEY, 3'h2, {24'h0, rpa_pkg::KEY_SECOND});
        wr(rpa_pkg::OFS_CLOCK_CONFIG, 3'h2, 32'h0000_2000);
        check_port(time_write_enable, 0);
        wr(rpa_pkg::OFS_UNLOCK_KEY, 3'h2, {24'h0, rpa_pkg::KEY_FIRST});
        wr(rpa_pkg::OFS_UNLOCK_KEY, 3'h2, {24'h0, rpa_pkg::KEY_SECOND});
        wr(rpa_pkg::OFS_CLOCK_CONFIG, 3'h2, 32'h0000_2000);
        check_port(time_write_enable, 1);
        run_window(0, rpa_pkg::OFS_CLOCK_CONFIG, rpa_pkg::OFS_TIME_WINDOW);
        // Enable cleared once the update is done
        wr(rpa_pkg::OFS_CLOCK_CONFIG, 3'h2, 32'h0);
        check_port(time_write_enable, 0);
        wr(rpa_pkg::OFS_TIME_WINDOW, 3'h2, rnd());
        rdw(rpa_pkg::OFS_TIME_WINDOW, rd);
        check_data(rd, exp_read(0, 0));
        // Alarm window is not behind the enable
        run_window(1, rpa_pkg::OFS_ALARM_CONFIG, rpa_pkg::OFS_ALARM_WINDOW);
        rdw(6'h18, rd);
        check_data(rd, 32'h0);
        rdw(rpa_pkg::OFS_UNLOCK_KEY, rd);
        check_data(rd, 32'h0);
        wrap_up();
    end
endmodule
`default_nettype wire
